// File: core/trwl_loader.sv
`timescale 1ns/100ps
`include "trwl_params.svh"

// ----------------------------------------------------------------------------
// Word FIFO between the host strobe and the channel write port.
// ----------------------------------------------------------------------------
module trwl_fifo #(
  parameter int Width = 22,
  parameter int Depth = 8
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic inValid, // Write request.
  output logic inReady, // Space available.
  input wire logic [Width-1:0] inData, // Word written.
  output logic outValid, // Word available.
  input wire logic outReady, // Reader takes the word.
  output logic [Width-1:0] outData // Oldest word.
);
  localparam int PtrW = $clog2(Depth);
  logic [Width-1:0] mem_q [Depth]; // Storage array.
  logic [PtrW-1:0] wrPtr_q, wrPtr_d; // Write pointer.
  logic [PtrW-1:0] rdPtr_q, rdPtr_d; // Read pointer.
  logic [PtrW:0] count_q, count_d; // Words held.
  logic push, pop; // Accepted transfers.

  assign inReady = (count_q != Depth[PtrW:0]);
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Next pointer and count values.
  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + {{PtrW{1'b0}}, push} - {{PtrW{1'b0}}, pop};
  end

  // Pointer registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage is written only on an accepted push and needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule : trwl_fifo

// ----------------------------------------------------------------------------
// Configuration word loader and divider readback.
// ----------------------------------------------------------------------------
module trwl_loader (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire trwl_pkg::trwl_mode_t opMode, // Image or rate-division mode.
  input wire trwl_pkg::trwl_cfg_t imgConfig, // Configuration of the image.
  input wire logic directAnalog, // Image is a direct analog image.
  input wire logic reducedEn, // Reduced image operation.
  input wire logic [`TRWL_CHAN_W-1:0] channelAddr, // Target channel.
  input wire logic startLoad, // Begin applying an image.
  input wire logic writeAll, // Word strobe.
  output logic writeAllReady, // Loader accepts a word.
  input wire logic [`TRWL_DATA_W-1:0] wordData, // Word data.
  input wire logic [`TRWL_ADDR_W-1:0] wordAddrIn, // Reduced entry address.
  input wire logic reducedLast, // Last reduced entry.
  output logic [`TRWL_ADDR_W-1:0] wordAddrOut, // Word now needed.
  output logic reconfigDone, // Image applied.
  output logic busy, // Image in progress.
  output logic analogDefaultsLoad, // Load analog defaults pulse.
  output logic [`TRWL_CHAN_W-1:0] chanSel, // Channel being written.
  output logic chanWrValid, // Word for the channel.
  input wire logic chanWrReady, // Channel takes the word.
  output trwl_pkg::trwl_entry_t chanWr, // Word and its address.
  input wire logic rateWrite, // Write divider code.
  input wire logic [1:0] rateCtrl, // Divider code to write.
  input wire logic rateRead, // Read divider code.
  output logic [1:0] rateOut, // Divider readback.
  output logic [1:0] txDivider // Divider of the selected channel.
);
  import trwl_pkg::*;

  // --------------------------------------------------------------------------
  // State registers.
  // --------------------------------------------------------------------------
  trwl_state_t state_q, state_d; // Loader state.
  logic [`TRWL_ADDR_W-1:0] addr_q, addr_d; // Word address counter.
  logic [`TRWL_ADDR_W-1:0] len_q, len_d; // Image length.
  logic reduced_q, reduced_d; // Reduced image latched at start.
  logic done_q, done_d; // Done flag.
  logic analog_q, analog_d; // Analog defaults pulse.
  logic [`TRWL_CHAN_W-1:0] chan_q, chan_d; // Latched channel.
  logic [1:0] div_q [`TRWL_CHAN_N]; // Divider per channel.
  logic [1:0] div_d [`TRWL_CHAN_N]; // Next dividers.
  logic [1:0] rate_q, rate_d; // Readback register.
  logic [`TRWL_ADDR_W-1:0] imgLen; // Length from configuration.
  logic start, accept, lastWord; // Decoded events.
  logic fifoInReady; // FIFO has space.
  trwl_entry_t fifoIn; // Entry pushed into the FIFO.

  // Image length per configuration, taken from the table with no cap at the legal maximum.
  always_comb begin
    case (imgConfig)
      CFG_DUPLEX: imgLen = directAnalog ? `TRWL_LEN_DUPLEX_DA : `TRWL_LEN_DUPLEX;
      CFG_RX_ONLY: imgLen = directAnalog ? `TRWL_LEN_RX_DA : `TRWL_LEN_RX;
      CFG_TX_ONLY: imgLen = directAnalog ? `TRWL_LEN_TX_DA : `TRWL_LEN_TX;
      default: imgLen = directAnalog ? `TRWL_LEN_CENTRAL_DA : `TRWL_LEN_CENTRAL;
    endcase
  end

  // Images start only in image mode and while no image is in progress.
  assign start = startLoad && (opMode == MODE_IMAGE) && !busy;
  assign busy = (state_q == ST_LOAD) || (state_q == ST_DRAIN);
  assign writeAllReady = (state_q == ST_LOAD) && fifoInReady;
  assign accept = writeAll && writeAllReady;
  assign lastWord = reduced_q ? reducedLast : (addr_q == len_q - 1'b1);
  // Reduced entries carry their own address, full ones the counter.
  assign fifoIn.addr = reduced_q ? wordAddrIn : addr_q;
  assign fifoIn.data = wordData;

  // --------------------------------------------------------------------------
  // Loader next-state logic.
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    len_d = len_q;
    reduced_d = reduced_q;
    done_d = done_q;
    analog_d = 1'b0;
    chan_d = chan_q;
    case (state_q)
      ST_IDLE, ST_DONE: begin
        if (start) begin
          state_d = ST_LOAD;
          addr_d = '0;
          len_d = imgLen;
          reduced_d = reducedEn;
          done_d = 1'b0;
          analog_d = 1'b1;
          chan_d = channelAddr;
        end
      end
      ST_LOAD: begin
        if (accept) begin
          if (lastWord) begin
            state_d = ST_DRAIN;
          end else if (!reduced_q) begin
            addr_d = addr_q + 1'b1;
          end
        end
      end
      ST_DRAIN: begin
        // Done once every buffered word has reached the channel.
        if (!chanWrValid) begin
          state_d = ST_DONE;
          done_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Loader registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      len_q <= `TRWL_LEN_DUPLEX;
      reduced_q <= 1'b0;
      done_q <= 1'b0;
      analog_q <= 1'b0;
      chan_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      len_q <= len_d;
      reduced_q <= reduced_d;
      done_q <= done_d;
      analog_q <= analog_d;
      chan_q <= chan_d;
    end
  end

  assign wordAddrOut = addr_q;
  assign reconfigDone = done_q;
  assign analogDefaultsLoad = analog_q;
  assign chanSel = chan_q;

  // --------------------------------------------------------------------------
  // Word buffer; a stalled channel fills it and drops writeAllReady.
  // --------------------------------------------------------------------------
  trwl_fifo #(
    .Width(`TRWL_ENTRY_W),
    .Depth(`TRWL_FIFO_DEPTH)
  ) trwl_fifo_inst (
    .clk(clk),
    .reset(reset),
    .inValid(accept),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(chanWrValid),
    .outReady(chanWrReady),
    .outData(chanWr)
  );

  // --------------------------------------------------------------------------
  // Transmit divider store and readback.
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `TRWL_CHAN_N; i++) begin
      div_d[i] = div_q[i];
    end
    if (rateWrite && opMode == MODE_RATE_DIV) begin
      div_d[channelAddr] = rateCtrl;
    end
    // Readback keeps the same codes as the control input.
    rate_d = (rateRead && opMode == MODE_RATE_DIV) ? div_q[channelAddr] : rate_q;
  end

  // Divider registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `TRWL_CHAN_N; i++) begin
        div_q[i] <= `TRWL_DIV_RESET;
      end
      rate_q <= `TRWL_DIV_RESET;
    end else begin
      div_q <= div_d;
      rate_q <= rate_d;
    end
  end

  assign rateOut = rate_q;
  assign txDivider = div_q[channelAddr];

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  sequence sStart;
    startLoad && opMode == MODE_IMAGE && !busy;
  endsequence
  sequence sFullWord;
    accept && !reduced_q && !lastWord;
  endsequence

  addr_clear_a: assert property (@(posedge clk) disable iff (reset)
    sStart |=> wordAddrOut == '0) else $error("Address not cleared at start.");
  addr_step_a: assert property (@(posedge clk) disable iff (reset)
    sFullWord |=> wordAddrOut == $past(wordAddrOut) + 1'b1) else $error("Address did not step.");
  reduced_hold_a: assert property (@(posedge clk) disable iff (reset)
    accept && reduced_q |=> $stable(wordAddrOut)) else $error("Reduced address moved.");
  analog_pulse_a: assert property (@(posedge clk) disable iff (reset)
    sStart |=> analogDefaultsLoad ##1 !analogDefaultsLoad) else $error("Analog load not one pulse.");
  len_bound_a: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_LOAD |-> wordAddrOut < len_q) else $error("Address past image end.");
  done_set_a: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_DRAIN && !chanWrValid |=> reconfigDone && !busy) else $error("Done not set.");
  ready_mode_a: assert property (@(posedge clk) disable iff (reset)
    opMode == MODE_RATE_DIV && !busy |=> !busy && !writeAllReady) else $error("Load began in rate mode.");
  rate_read_a: assert property (@(posedge clk) disable iff (reset)
    rateRead && opMode == MODE_RATE_DIV && !rateWrite |=> rateOut == $past(txDivider))
    else $error("Readback does not match divider.");
  rate_code_a: assert property (@(posedge clk) disable iff (reset)
    rateWrite && opMode == MODE_RATE_DIV ##1 rateRead && opMode == MODE_RATE_DIV
      && $stable(channelAddr) && !rateWrite |=> rateOut == $past(rateCtrl, 2))
    else $error("Readback code differs from written code.");
endmodule : trwl_loader

// File: pkg/trwl_params.svh
`ifndef TRWL_PARAMS_SVH
`define TRWL_PARAMS_SVH
// ----------------------------------------------------------------------------
// Widths, counts and limits of the word path.
// ----------------------------------------------------------------------------
`define TRWL_DATA_W 16
`define TRWL_ADDR_W 6
`define TRWL_ENTRY_W 22
`define TRWL_CHAN_N 4
`define TRWL_CHAN_W 2
`define TRWL_FIFO_DEPTH 8
`define TRWL_MAX_WORDS 6'd59
// ----------------------------------------------------------------------------
// Image lengths in words, normal and direct analog.
// ----------------------------------------------------------------------------
`define TRWL_LEN_DUPLEX 6'd55
`define TRWL_LEN_DUPLEX_DA 6'd27
`define TRWL_LEN_RX 6'd37
`define TRWL_LEN_RX_DA 6'd14
`define TRWL_LEN_TX 6'd19
`define TRWL_LEN_TX_DA 6'd15
`define TRWL_LEN_CENTRAL 6'd60
`define TRWL_LEN_CENTRAL_DA 6'd33
// ----------------------------------------------------------------------------
// Divider codes and reset values.
// ----------------------------------------------------------------------------
`define TRWL_DIV_BY1 2'h0
`define TRWL_DIV_BY2 2'h1
`define TRWL_DIV_BY4 2'h2
`define TRWL_DIV_RESET 2'h0
`endif

// File: pkg/trwl_pkg.sv
`include "trwl_params.svh"
package trwl_pkg;
  // Transceiver configuration that produced the image.
  typedef enum logic [1:0] {
    CFG_DUPLEX = 2'h0,
    CFG_RX_ONLY = 2'h1,
    CFG_TX_ONLY = 2'h2,
    CFG_DUPLEX_CENTRAL = 2'h3
  } trwl_cfg_t;
  // Operating mode of the controller.
  typedef enum logic {
    MODE_IMAGE = 1'b0,
    MODE_RATE_DIV = 1'b1
  } trwl_mode_t;
  // Loader states, Gray coded along idle, load, drain, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_DRAIN = 2'h3,
    ST_DONE = 2'h2
  } trwl_state_t;
  // One word on its way to the channel.
  typedef struct packed {
    logic [`TRWL_ADDR_W-1:0] addr;
    logic [`TRWL_DATA_W-1:0] data;
  } trwl_entry_t;
endpackage : trwl_pkg

// File: dv/trwl_word_feeder.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Host memory that streams a full image into the loader.
// ----------------------------------------------------------------------------
module trwl_word_feeder (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic go, // Loads the word count and starts a stream.
  input wire logic [5:0] wordCount, // Words in the image.
  input wire logic ready, // Loader takes a word.
  input wire logic [5:0] addr, // Word the loader needs.
  output logic strobe, // Word strobe.
  output logic [15:0] data // Word read from memory.
);
  logic [5:0] left_q; // Words still to send.
  // The strobe stays up until the count runs out, one word per handshake.
  assign strobe = (left_q != 6'h0);
  // Memory answers with the addressed word; an idle bus shows its inverse.
  assign data = strobe ? {addr, ~addr, 4'h5} : ~{addr, ~addr, 4'h5};
  // Only an edge with strobe and ready both high removes a word.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left_q <= 6'h0;
    end else if (go) begin
      left_q <= wordCount;
    end else if (strobe && ready) begin
      left_q <= left_q - 6'h1;
    end
  end
endmodule : trwl_word_feeder

// File: dv/trwl_loader_bench.sv
`timescale 1ns/100ps
`include "trwl_params.svh"
// ----------------------------------------------------------------------------
// Bench for the word loader.
// ----------------------------------------------------------------------------
module trwl_loader_bench;
  import trwl_pkg::*;
  logic clk = 0, reset = 1, directAnalog = 0, reducedEn = 0, startLoad = 0;
  logic tbOwn = 0, tbWrite = 0, reducedLast = 0, rateWrite = 0, rateRead = 0;
  logic chanWrReady = 0, hold = 0, go = 0, writeAll, writeAllReady, fdStrobe;
  logic reconfigDone, busy, analogDefaultsLoad, chanWrValid;
  logic [1:0] channelAddr = 0, rateCtrl = 0, chanSel, rateOut, txDivider;
  logic [15:0] tbData = 0, fdData, wordData;
  logic [5:0] wordAddrIn = 0, wordAddrOut, feedCount = 0;
  trwl_mode_t opMode = MODE_IMAGE;
  trwl_cfg_t imgConfig = CFG_DUPLEX;
  trwl_entry_t chanWr;
  trwl_entry_t got[$]; // Entries popped by the channel.
  int n_mismatch = 0, checks_done = 0, nAdl = 0, cyc = 0, i;
  // Rows: configuration, direct analog, image length.
  logic [8:0] rows [8] = '{9'h037, 9'h05b, 9'h0a5, 9'h0ce,
                           9'h113, 9'h14f, 9'h1bc, 9'h1e1};
  // The bench takes the word bus over for reduced entries.
  assign writeAll = tbOwn ? tbWrite : fdStrobe;
  assign wordData = tbOwn ? tbData : fdData;
  trwl_loader trwl_loader_inst (.clk, .reset, .opMode, .imgConfig, .directAnalog,
    .reducedEn, .channelAddr, .startLoad, .writeAll, .writeAllReady, .wordData,
    .wordAddrIn, .reducedLast, .wordAddrOut, .reconfigDone, .busy,
    .analogDefaultsLoad, .chanSel, .chanWrValid, .chanWrReady, .chanWr,
    .rateWrite, .rateCtrl, .rateRead, .rateOut, .txDivider);
  trwl_word_feeder trwl_word_feeder_inst (.clk(clk), .reset(reset), .go(go),
    .wordCount(feedCount), .ready(writeAllReady), .addr(wordAddrOut),
    .strobe(fdStrobe), .data(fdData));
  // Clock of 40 ns.
  initial begin
    forever #20 clk = ~clk;
  end
  // Channel sink stalls every other cycle, or fully while hold is up.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (chanWrValid === 1'b1 && chanWrReady) got.push_back(chanWr);
    if (analogDefaultsLoad === 1'b1) nAdl++;
    chanWrReady <= #1 !hold && !chanWrReady;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [21:0] g, input logic [21:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // Waits for the done flag under a bound.
  task automatic waitDone();
    int k;
    k = 0;
    while (reconfigDone !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
    chk(22'(k < 3000), 22'h1);
  endtask : waitDone
  // Starts an image load and clears the observations.
  task automatic begin_load(input trwl_cfg_t c, input logic da, input logic [5:0] n);
    got.delete();
    nAdl = 0;
    imgConfig = c;
    directAnalog = da;
    channelAddr = 2'h3 ^ c;
    feedCount = n;
    startLoad = 1;
    go = !tbOwn;
    tick();
    startLoad = 0;
    go = 0;
  endtask : begin_load
  // Full image; optionally stalls the channel until the FIFO refuses.
  task automatic runImg(input trwl_cfg_t c, input logic da, input logic [5:0] n,
                        input logic stall);
    hold = stall;
    begin_load(c, da, n);
    if (stall) begin
      repeat (20) tick();
      chk(22'(writeAllReady), 22'h0);
      startLoad = 1;
      tick();
      startLoad = 0;
      hold = 0;
    end
    waitDone();
    chk(22'(got.size()), 22'(n));
    for (i = 0; i < got.size(); i++) begin
      chk(got[i], {6'(i), 6'(i), ~6'(i), 4'h5});
    end
    chk(22'(chanSel), 22'(2'h3 ^ c));
    chk(22'(nAdl), 22'h1);
    $display("image test %0d done", c);
  endtask : runImg
  // Writes one reduced entry and waits for it to be taken.
  task automatic wrEnt(input logic [5:0] a, input logic [15:0] d, input logic l);
    wordAddrIn = a;
    tbData = d;
    reducedLast = l;
    tbWrite = 1;
    while (writeAllReady !== 1'b1) tick();
    tick();
  endtask : wrEnt
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset = 0;
    chk(22'({reconfigDone, busy, chanWrValid, rateOut, wordAddrOut}), 22'h0);
    for (int r = 0; r < 8; r++) begin
      runImg(trwl_cfg_t'(rows[r][8:7]), rows[r][6], rows[r][5:0], 1'b0);
    end
    runImg(CFG_TX_ONLY, 1'b0, 6'h13, 1'b1);
    // Reduced image: only the addressed words reach the channel.
    tbOwn = 1;
    reducedEn = 1;
    begin_load(CFG_DUPLEX, 1'b0, 6'h0);
    wrEnt(6'h20, 16'hbeef, 1'b0);
    wrEnt(6'h3a, 16'h1234, 1'b1);
    tbWrite = 0;
    waitDone();
    chk(22'(got.size()), 22'h2);
    chk(got[0], {6'h20, 16'hbeef});
    chk(got[1], {6'h3a, 16'h1234});
    tbOwn = 0;
    reducedEn = 0;
    $display("reduced test done");
    // Rate division: write each code, read it back.
    opMode = MODE_RATE_DIV;
    for (int c = 0; c < 3; c++) begin
      channelAddr = 2'(c + 1);
      rateCtrl = 2'(c);
      rateWrite = 1;
      tick();
      rateWrite = 0;
      rateRead = 1;
      tick();
      rateRead = 0;
      chk(22'(rateOut), 22'(c));
      chk(22'(txDivider), 22'(c));
    end
    startLoad = 1;
    tick();
    startLoad = 0;
    chk(22'(busy), 22'h0);
    opMode = MODE_IMAGE;
    channelAddr = 2'h3;
    rateCtrl = 2'h1;
    rateWrite = 1;
    tick();
    rateWrite = 0;
    tick();
    chk(22'(txDivider), 22'h2);
    $display("rate test done");
    wrap_up();
  end
endmodule : trwl_loader_bench
